//--- inc/checksum_pkg.sv
// Function
// RULE_01: sum every program word from zero up to the top user address parameter.
// RULE_02: drop carries above bit 15; result is the low 16 bits.
// RULE_03: after memory words add the configuration word masked with 0x3f3f.
// RULE_04: id term packs low nibbles of four id words, first id most significant.
// RULE_05: address ranges include both end addresses.
// RULE_06: protection setting picks terms; protected parts also add the id term.
// RULE_07: from an image, protected words are zeroed to match a protected part read.
// RULE_08: programmer reads whole memory from a part; config and id always readable.
// RULE_09: clear at start, one word per valid cycle, done with result after terms.
// RULE_10: protected segments read as zeros and add nothing.
`default_nettype none
package checksum_pkg;
	localparam logic [15:0] CFG_MASK = 16'h3f3f;
	localparam logic [15:0] ID_NIBBLE_MASK = 16'h000f;
	localparam logic [15:0] SUM_RESET = 16'h0000;
	localparam int ID_COUNT = 4;
	localparam int DEFAULT_TOP_ADDR = 'h1ff;
	localparam int DEFAULT_ADDR_W = 13;
	// protection levels as given on the setting input
	typedef enum logic [1:0] {
		PROT_OFF = 2'b00,
		PROT_HALF = 2'b01,
		PROT_3Q = 2'b10,
		PROT_ALL = 2'b11
	} prot_e;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_MEM = 3'b001,
		ST_CFG = 3'b010,
		ST_ID = 3'b011,
		ST_DONE = 3'b100
	} state_e;
endpackage
`default_nettype wire

//--- design/id_nibble_pack.sv
`timescale 1ns/1ps
`default_nettype none
module id_nibble_pack
	import checksum_pkg::*;
(
	// raw id words
	input wire logic [15:0] firstIdWord,
	input wire logic [15:0] idWord1,
	input wire logic [15:0] idWord2,
	input wire logic [15:0] idWord3,
	// packed term
	output logic [15:0] idNibbleWord
);
	// first id word lands in the top nibble
	assign idNibbleWord = {firstIdWord[3:0], idWord1[3:0], idWord2[3:0], idWord3[3:0]}; // RULE_04
endmodule
`default_nettype wire

//--- design/program_memory_checksum.sv
`timescale 1ns/1ps
`default_nettype none
module program_memory_checksum
	import checksum_pkg::*;
#(
	parameter int ADDR_W = DEFAULT_ADDR_W,
	parameter logic [ADDR_W-1:0] TOP_ADDR = ADDR_W'(DEFAULT_TOP_ADDR)
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// computation control
	input wire logic start,
	input wire logic fromImage,
	input wire logic [1:0] protLevel,
	input wire logic [ADDR_W-1:0] protBase,
	// memory word stream
	input wire logic wordValid,
	input wire logic [15:0] wordData,
	output logic wordReady,
	// side terms
	input wire logic [15:0] configWord,
	input wire logic [15:0] firstIdWord,
	input wire logic [15:0] idWord1,
	input wire logic [15:0] idWord2,
	input wire logic [15:0] idWord3,
	// result
	output logic busy,
	output logic done,
	output logic [15:0] checksum
);
	state_e state;
	logic [ADDR_W-1:0] addr;
	logic [15:0] sum;
	logic [15:0] idNibbleWord;
	logic [15:0] configWordTerm;
	logic [15:0] memTerm;
	logic protectOn;
	logic wordTaken;

	id_nibble_pack packer (
		.firstIdWord(firstIdWord),
		.idWord1(idWord1),
		.idWord2(idWord2),
		.idWord3(idWord3),
		.idNibbleWord(idNibbleWord)
	);

	assign configWordTerm = configWord & CFG_MASK; // RULE_03
	assign protectOn = (protLevel != PROT_OFF); // RULE_06
	// image words from the protected base up are zeroed, like a protected part reads
	assign memTerm = (fromImage && protectOn && addr >= protBase) ? 16'h0000 : wordData; // RULE_07 RULE_10
	assign wordReady = (state == ST_MEM);
	assign wordTaken = wordReady && wordValid;
	assign busy = (state != ST_IDLE) && (state != ST_DONE);

	// sequence: memory words, then config term, then optional id term
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= ST_IDLE;
		end else if (start) begin
			state <= ST_MEM; // RULE_09
		end else begin
			case (state)
				ST_MEM: begin
					if (wordTaken && addr == TOP_ADDR) begin
						state <= ST_CFG; // RULE_05
					end
				end
				ST_CFG: begin
					state <= protectOn ? ST_ID : ST_DONE; // RULE_06
				end
				ST_ID: begin
					state <= ST_DONE;
				end
				ST_IDLE, ST_DONE: begin
					state <= state;
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// word address tracks which location the next word is
	always_ff @(posedge clk) begin
		if (rst || start) begin
			addr <= '0;
		end else if (wordTaken) begin
			addr <= addr + 1'b1; // RULE_01
		end
	end

	// 16-bit adder naturally drops carries out of bit 15
	always_ff @(posedge clk) begin
		if (rst || start) begin
			sum <= SUM_RESET; // RULE_09
		end else if (wordTaken) begin
			sum <= sum + memTerm; // RULE_01 RULE_02
		end else if (state == ST_CFG) begin
			sum <= sum + configWordTerm; // RULE_03
		end else if (state == ST_ID) begin
			sum <= sum + idNibbleWord; // RULE_04
		end
	end

	// result and done flag registered together
	always_ff @(posedge clk) begin
		if (rst || start) begin
			done <= 1'b0;
			checksum <= SUM_RESET;
		end else if ((state == ST_CFG && !protectOn) || state == ST_ID) begin
			done <= 1'b1; // RULE_09
			checksum <= sum + (state == ST_ID ? idNibbleWord : configWordTerm);
		end
	end

	// final sum includes config term in the same cycle done rises
	cfg_done_a: assert property (@(posedge clk) disable iff (rst)
		(state == ST_CFG && !protectOn && !start) |=> done && checksum == $past(sum) + $past(configWordTerm)) // RULE_03
		else $error("config term not added at done");
	id_done_a: assert property (@(posedge clk) disable iff (rst)
		(state == ST_ID && !start) |=> done && checksum == $past(sum) + $past(idNibbleWord)) // RULE_04
		else $error("id term not added at done");
	prot_id_a: assert property (@(posedge clk) disable iff (rst)
		(state == ST_CFG && protectOn && !start) |=> state == ST_ID) // RULE_06
		else $error("protected part skipped id term");
	start_clear_a: assert property (@(posedge clk) disable iff (rst)
		start |=> sum == 16'h0000 && !done && addr == '0) // RULE_09
		else $error("start did not clear");
	word_add_a: assert property (@(posedge clk) disable iff (rst)
		(wordTaken && !start) |=> sum == 16'($past(sum) + $past(memTerm))) // RULE_02
		else $error("word not added modulo 16 bits");
	top_end_a: assert property (@(posedge clk) disable iff (rst)
		(wordTaken && addr == TOP_ADDR && !start) |=> state == ST_CFG) // RULE_05
		else $error("range end not inclusive");
	mid_stay_a: assert property (@(posedge clk) disable iff (rst)
		(wordTaken && addr != TOP_ADDR && !start) |=> state == ST_MEM && addr == $past(addr) + 1'b1) // RULE_01
		else $error("memory range stopped early");
	image_zero_a: assert property (@(posedge clk) disable iff (rst)
		(wordTaken && fromImage && protectOn && addr >= protBase && !start) |=> sum == $past(sum)) // RULE_07
		else $error("protected image word added");

	// finishing steps after the last word, built from small sequences
	sequence last_word_s;
		wordTaken && addr == TOP_ADDR;
	endsequence
	sequence cfg_step_s;
		state == ST_CFG && !wordReady;
	endsequence
	sequence id_step_s;
		state == ST_ID && !done;
	endsequence
	sequence finished_s;
		done && !busy && !wordReady;
	endsequence

	// unprotected part: one config step, then done
	unprot_finish_a: assert property (@(posedge clk) disable iff (rst || start) // RULE_06
		(last_word_s and !protectOn) |=> cfg_step_s ##1 finished_s)
		else $error("unprotected finish sequence wrong");
	// protected part: config step, id step, then done
	prot_finish_a: assert property (@(posedge clk) disable iff (rst || start) // RULE_06
		(last_word_s and protectOn) |=> cfg_step_s ##1 id_step_s ##1 finished_s)
		else $error("protected finish sequence wrong");
	// result must stand until the next start or reset
	done_hold_a: assert property (@(posedge clk) disable iff (rst) // RULE_09
		(done && !start) |=> done && $stable(checksum))
		else $error("result did not stand");
	// reset leaves the block idle with a cleared result
	reset_idle_a: assert property (@(posedge clk) // RULE_09
		rst |=> !done && !busy && !wordReady && checksum == 16'h0000)
		else $error("reset did not idle the block");
	// no word may be accepted outside the memory phase
	word_phase_a: assert property (@(posedge clk) disable iff (rst) // RULE_09
		(state != ST_MEM) |-> !wordTaken)
		else $error("word taken outside memory phase");
	// done only ever rises out of a config or id step
	done_rise_a: assert property (@(posedge clk) disable iff (rst) // RULE_09
		$rose(done) |-> $past(state) == ST_CFG || $past(state) == ST_ID)
		else $error("done rose from wrong phase");
endmodule
`default_nettype wire

//--- tb/word_source.sv
`timescale 1ns/1ps
`default_nettype none
module word_source #(
	parameter int N = 4
) (
	// clock and control
	input wire logic clk,
	input wire logic start,
	input wire logic zeroOn,
	input wire logic [12:0] zeroFrom,
	// word stream
	input wire logic wordReady,
	output logic wordValid,
	output logic [15:0] wordData
);
	logic [15:0] mem [N];
	int addr = N;
	// address moves only on a taken word, so a stall holds the word
	always @(posedge clk) begin
		if (start) addr <= #1 0;
		else if (wordValid && wordReady) addr <= #1 addr + 1;
	end
	// whole memory offered as read; past the top the line shows the inverse
	assign wordValid = addr < N;
	assign wordData = !wordValid ? ~mem[N-1] :
		(zeroOn && addr >= zeroFrom) ? 16'h0000 : mem[addr];
endmodule
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import checksum_pkg::*;
	localparam int TOP = 3;
	logic clk, rst, start, fromImage, zeroOn, wordValid, wordReady, busy, done;
	logic [1:0] protLevel;
	logic [12:0] protBase;
	logic [15:0] wordData, configWord, id0, id1, id2, id3, checksum, sum, exp;
	int err_count, cmp_count;
	program_memory_checksum #(.ADDR_W(13), .TOP_ADDR(13'(TOP))) dut_u (.clk(clk), .rst(rst),
		.start(start), .fromImage(fromImage), .protLevel(protLevel), .protBase(protBase),
		.wordValid(wordValid), .wordData(wordData), .wordReady(wordReady),
		.configWord(configWord), .firstIdWord(id0), .idWord1(id1), .idWord2(id2),
		.idWord3(id3), .busy(busy), .done(done), .checksum(checksum));
	word_source #(.N(TOP + 1)) src_u (.clk(clk), .start(start), .zeroOn(zeroOn),
		.zeroFrom(protBase), .wordReady(wordReady), .wordValid(wordValid), .wordData(wordData));
	// free running clock
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	task test_done;
		$display("errors %0d compares %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task check(input logic [15:0] seen, input logic [15:0] want);
		cmp_count++;
		if (seen !== want) begin
			err_count++;
			$display("mismatch at %0t: got %h want %h", $time, seen, want);
		end
	endtask
	// one computation; latency counted in edges after the start edge
	task run(input int lat);
		int n;
		start = 1;
		@(posedge clk) #1 start = 0;
		check(16'(busy), 16'h0001);
		check(16'(wordReady), 16'h0001);
		n = 0;
		while (done !== 1'b1 && n < 20) begin
			@(posedge clk) #1 n++;
		end
		if (n == 20) begin
			err_count++;
			test_done;
		end
		check(16'(n), 16'(lat));
		check(16'(busy), 16'h0000);
		sum = checksum;
	endtask
	// reset in mid-run must drop back to idle with a cleared result
	task scen_reset;
		start = 1;
		@(posedge clk) #1 start = 0;
		repeat (2) @(posedge clk);
		#1 rst = 1;
		@(posedge clk) #1 rst = 0;
		check(16'(done), 16'h0000);
		check(16'(busy), 16'h0000);
		check(16'(wordReady), 16'h0000);
		check(checksum, 16'h0000);
		@(posedge clk) #1;
		check(16'(busy), 16'h0000);
	endtask
	// large words force carries out of bit 15
	task scen_wrap;
		exp = 16'h3f3f;
		for (int i = 0; i <= TOP; i++) begin
			src_u.mem[i] = 16'hc000 + 16'(i);
			exp += 16'hc000 + 16'(i);
		end
		configWord = 16'hffff;
		run(TOP + 2);
		check(sum, exp);
		check(sum, 16'h3f45);
	endtask
	// image with each protected level (1 to 3); words from protBase up are zeroed
	task scen_image;
		fromImage = 1;
		configWord = 16'hc0c3;
		{id0, id1, id2, id3} = {16'h0012, 16'h0037, 16'h0004, 16'h0026};
		for (int l = 1; l <= 3; l++) begin
			protLevel = 2'(l);
			protBase = 13'(l);
			exp = 16'h2746 + 16'h0003;
			for (int i = 0; i <= TOP; i++) begin
				src_u.mem[i] = 16'h0001 << (4 * i);
				if (i < l) exp += 16'h0001 << (4 * i);
			end
			run(TOP + 3);
			check(sum, exp);
		end
	endtask
	// fully protected part reads back zeros; only config and id terms remain
	task scen_part;
		fromImage = 0;
		protLevel = PROT_ALL;
		protBase = 0;
		zeroOn = 1;
		run(TOP + 3);
		check(sum, 16'h2749);
	endtask
	initial begin
		err_count = 0;
		cmp_count = 0;
		{rst, start, fromImage, zeroOn, protLevel, protBase} = {1'b1, 18'h0};
		{configWord, id0, id1, id2, id3} = '0;
		repeat (5) @(posedge clk);
		#1 rst = 0;
		scen_wrap;
		scen_image;
		scen_reset;
		scen_part;
		test_done;
	end
endmodule
`default_nettype wire
